//--- csa_pkg.sv
// Purpose: Constants and types for the controller status and admin
//          queue attribute register group.
// Assumes: 50 MHz pclk, APB with 32-bit data, byte addresses.
// Notes:   Register offsets are byte addresses, one word each.

package csa_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_STATUS = 12'h01c;
  localparam logic [11:0] ADDR_SSR_TRIGGER = 12'h020;
  localparam logic [11:0] ADDR_QSIZE = 12'h024;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int ST_READY_BIT = 0;
  localparam int ST_FATAL_BIT = 1;
  localparam int ST_SHDN_LSB = 2;
  localparam int ST_SEEN_BIT = 4;
  localparam int ST_PAUSED_BIT = 5;
  localparam int QSIZE_W = 12;
  localparam int SQ_SIZE_LSB = 0;
  localparam int CQ_SIZE_LSB = 16;
  localparam int QID_W = 16;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [31:0] SSR_KEY = 32'h4e564d65;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [11:0] QSIZE_RESET = 12'h000;
  localparam logic [15:0] ADMIN_QID = 16'h0000;

  typedef enum logic [1:0] {
    SD_NORMAL = 2'b00,
    SD_BUSY = 2'b01,
    SD_DONE = 2'b10
  } csa_shdn_code_type;

  typedef enum logic [3:0] {
    RS_IDLE = 4'b0001,
    RS_STARTING = 4'b0010,
    RS_READY = 4'b0100,
    RS_STOPPING = 4'b1000
  } csa_ready_state_type;

  typedef enum logic [2:0] {
    SS_NORMAL = 3'b001,
    SS_BUSY = 3'b010,
    SS_DONE = 3'b100
  } csa_shdn_state_type;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int READY_TIME_NS = 200;
  localparam int STOP_TIME_NS = 100;
  localparam int SHDN_TIME_NS = 400;
  localparam int TIMER_W = 8;
  localparam int READY_CYC = (READY_TIME_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int STOP_CYC = (STOP_TIME_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
  localparam int SHDN_CYC = (SHDN_TIME_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;

endpackage : csa_pkg

//--- csa_timer.sv
// Purpose: Down-counting one-shot timer with a done pulse.
// Assumes: load is at least one; start restarts a running count.
// Notes:   done is registered and lasts one cycle.

`timescale 1ns/1ns

module csa_timer
  import csa_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);

  logic [W-1:0] count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= load;
        busy <= 1'b1;
      end else if (busy) begin
        count_reg <= count_reg - 1'b1;
        if (count_reg == {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : csa_timer

//--- csa_regs.sv
// Purpose: APB register group: controller status, subsystem reset
//          trigger and admin queue sizes, with ready and shutdown
//          sequencing.
// Assumes: Status inputs are synchronous to pclk; zero wait states.
// Notes:   Init-time levels are captured on the first edge after
//          reset release, never under the asynchronous reset.

`timescale 1ns/1ns

module csa_regs
  import csa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic controller_go,
  input wire logic [1:0] shutdown_notify,
  input wire logic subsystem_reset_supported,
  input wire logic pause_request,
  input wire logic fatal_event,
  input wire logic init_fatal_error,
  input wire logic warm_subsystem_reset,
  input wire logic firmware_activated,
  output logic controller_ready,
  output logic controller_reset,
  output logic subsystem_reset_req,
  output logic [QSIZE_W-1:0] admin_sq_entries,
  output logic [QSIZE_W-1:0] admin_cq_entries,
  output logic [QID_W-1:0] admin_sq_id,
  output logic [QID_W-1:0] admin_cq_id
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_STATUS) || (a == ADDR_SSR_TRIGGER) ||
                (a == ADDR_QSIZE);
  endfunction : is_mapped

  logic setup_rd;
  logic access_wr;
  logic wr_status;
  logic wr_trigger;
  logic wr_qsize;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign setup_rd = psel && !penable && !pwrite;
  assign access_wr = psel && penable && pwrite && pready;
  assign wr_status = access_wr && (paddr == ADDR_STATUS);
  assign wr_trigger = access_wr && (paddr == ADDR_SSR_TRIGGER);
  assign wr_qsize = access_wr && (paddr == ADDR_QSIZE);

  // ----------------------------------------------------------------
  // Init-time capture
  // ----------------------------------------------------------------
  // Straps are read one edge after release so the async reset
  // branch loads constants only.
  logic init_done_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fatal error flag
  // ----------------------------------------------------------------
  logic fatal_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fatal_reg <= 1'b0;
    end else if (!init_done_reg) begin
      fatal_reg <= init_fatal_error;
    end else if (fatal_event) begin
      fatal_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Subsystem reset seen flag
  // ----------------------------------------------------------------
  logic seen_reg;
  logic seen_view;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
    end else if (!init_done_reg) begin
      seen_reg <= warm_subsystem_reset && !firmware_activated;
    end else if (wr_status && pwdata[ST_SEEN_BIT]) begin
      seen_reg <= 1'b0;
    end
  end

  // Without reset support the bit carries nothing, so hide it
  assign seen_view = seen_reg && subsystem_reset_supported;

  // ----------------------------------------------------------------
  // Processing paused
  // ----------------------------------------------------------------
  logic paused_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      paused_reg <= 1'b0;
    end else begin
      paused_reg <= controller_go && pause_request;
    end
  end

  // ----------------------------------------------------------------
  // Ready sequencing
  // ----------------------------------------------------------------
  csa_ready_state_type ready_state_reg;
  csa_ready_state_type ready_state_next;
  logic rt_start;
  logic [TIMER_W-1:0] rt_load;
  logic rt_done;

  always_comb begin
    ready_state_next = ready_state_reg;
    rt_start = 1'b0;
    rt_load = TIMER_W'(READY_CYC);
    case (ready_state_reg)
      RS_IDLE: begin
        if (controller_go) begin
          ready_state_next = RS_STARTING;
          rt_start = 1'b1;
        end
      end
      RS_STARTING: begin
        if (!controller_go) begin
          ready_state_next = RS_STOPPING;
          rt_start = 1'b1;
          rt_load = TIMER_W'(STOP_CYC);
        end else if (rt_done) begin
          ready_state_next = RS_READY;
        end
      end
      RS_READY: begin
        if (!controller_go) begin
          ready_state_next = RS_STOPPING;
          rt_start = 1'b1;
          rt_load = TIMER_W'(STOP_CYC);
        end
      end
      RS_STOPPING: begin
        if (rt_done) begin
          ready_state_next = RS_IDLE;
        end
      end
      default: begin
        ready_state_next = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_state_reg <= RS_IDLE;
    end else begin
      ready_state_reg <= ready_state_next;
    end
  end

  // Teardown of queues happens outside; sizes are never touched here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_reset <= 1'b0;
    end else begin
      controller_reset <= (ready_state_reg != RS_STOPPING) &&
                          (ready_state_next == RS_STOPPING);
    end
  end

  assign controller_ready = (ready_state_reg == RS_READY);

  csa_timer #(
    .W(TIMER_W)
  ) u_ready_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(rt_start),
    .load(rt_load),
    .busy(),
    .done(rt_done)
  );

  // ----------------------------------------------------------------
  // Shutdown sequencing
  // ----------------------------------------------------------------
  csa_shdn_state_type shdn_state_reg;
  csa_shdn_state_type shdn_state_next;
  logic st_start;
  logic st_done;
  logic [1:0] shdn_code;
  logic notify_any;

  assign notify_any = (shutdown_notify != 2'h0);

  always_comb begin
    shdn_state_next = shdn_state_reg;
    st_start = 1'b0;
    case (shdn_state_reg)
      SS_NORMAL: begin
        if (notify_any) begin
          shdn_state_next = SS_BUSY;
          st_start = 1'b1;
        end
      end
      SS_BUSY: begin
        if (!notify_any) begin
          shdn_state_next = SS_NORMAL;
        end else if (st_done) begin
          shdn_state_next = SS_DONE;
        end
      end
      SS_DONE: begin
        if (!notify_any) begin
          shdn_state_next = SS_NORMAL;
        end
      end
      default: begin
        shdn_state_next = SS_NORMAL;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shdn_state_reg <= SS_NORMAL;
    end else begin
      shdn_state_reg <= shdn_state_next;
    end
  end

  // The reserved code 11 can never be produced
  always_comb begin
    case (shdn_state_reg)
      SS_BUSY: shdn_code = SD_BUSY;
      SS_DONE: shdn_code = SD_DONE;
      default: shdn_code = SD_NORMAL;
    endcase
  end

  csa_timer #(
    .W(TIMER_W)
  ) u_shdn_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(st_start),
    .load(TIMER_W'(SHDN_CYC)),
    .busy(),
    .done(st_done)
  );

  // ----------------------------------------------------------------
  // Subsystem reset trigger
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subsystem_reset_req <= 1'b0;
    end else begin
      subsystem_reset_req <= wr_trigger && subsystem_reset_supported &&
                             (pwdata == SSR_KEY);
    end
  end

  // ----------------------------------------------------------------
  // Admin queue sizes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      admin_sq_entries <= QSIZE_RESET;
      admin_cq_entries <= QSIZE_RESET;
    end else if (wr_qsize) begin
      admin_sq_entries <= pwdata[SQ_SIZE_LSB +: QSIZE_W];
      admin_cq_entries <= pwdata[CQ_SIZE_LSB +: QSIZE_W];
    end
  end

  assign admin_sq_id = ADMIN_QID;
  assign admin_cq_id = ADMIN_QID;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] qsize_word;

  always_comb begin
    status_word = READ_ZERO;
    status_word[ST_READY_BIT] = controller_ready;
    status_word[ST_FATAL_BIT] = fatal_reg;
    status_word[ST_SHDN_LSB +: 2] = shdn_code;
    status_word[ST_SEEN_BIT] = seen_view;
    status_word[ST_PAUSED_BIT] = paused_reg;
    qsize_word = READ_ZERO;
    qsize_word[SQ_SIZE_LSB +: QSIZE_W] = admin_sq_entries;
    qsize_word[CQ_SIZE_LSB +: QSIZE_W] = admin_cq_entries;
  end

  // Latched in the setup cycle so the access phase sees flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= READ_ZERO;
    end else if (setup_rd) begin
      case (paddr)
        ADDR_STATUS: prdata <= status_word;
        ADDR_QSIZE: prdata <= qsize_word;
        ADDR_SSR_TRIGGER: prdata <= READ_ZERO;
        default: prdata <= READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int READY_MAX = 16;
  localparam int SHDN_MAX = 24;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rd_access(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && paddr == a ##1 psel && penable;
  endsequence

  sequence s_key_write;
    access_wr && paddr == ADDR_SSR_TRIGGER && pwdata == SSR_KEY;
  endsequence

  a_trigger_reads_zero: assert property (
    s_rd_access(ADDR_SSR_TRIGGER) |-> prdata == READ_ZERO)
    else $error("trigger register read not zero");

  a_key_starts_reset: assert property (
    s_key_write ##0 subsystem_reset_supported |=> subsystem_reset_req)
    else $error("key write did not request reset");

  a_nonkey_ignored: assert property (
    subsystem_reset_req |-> $past(pwdata) == SSR_KEY &&
    $past(access_wr))
    else $error("reset request without key write");

  a_unsupported_quiet: assert property (
    !subsystem_reset_supported |=> !subsystem_reset_req)
    else $error("reset request while unsupported");

  a_ready_drops: assert property (
    !controller_go |=> !controller_ready)
    else $error("ready held after go cleared");

  a_ready_rises: assert property (
    ready_state_reg == RS_IDLE && controller_go |=>
    ##[1:READY_MAX] (controller_ready || !controller_go))
    else $error("ready not reached after go");

  a_reset_pulse: assert property (
    controller_ready && !controller_go |=> controller_reset ##1
    !controller_reset)
    else $error("controller reset pulse missing");

  a_paused_gated: assert property (
    !$past(controller_go) |-> !paused_reg)
    else $error("paused shown while go low");

  a_fatal_sticky: assert property (
    init_done_reg && $past(init_done_reg) && $past(fatal_reg) |->
    fatal_reg)
    else $error("fatal flag dropped");

  a_shdn_code_legal: assert property (
    (shdn_code != 2'b11) and (!notify_any |=> shdn_code == SD_NORMAL))
    else $error("bad shutdown code");

  a_shdn_completes: assert property (
    shdn_state_reg == SS_NORMAL && notify_any ##1 notify_any[*3] |->
    ##[1:SHDN_MAX] (shdn_code == SD_DONE || !notify_any))
    else $error("shutdown never completes");

  a_qsize_write: assert property (
    wr_qsize |=> admin_sq_entries == $past(pwdata[11:0]) &&
    admin_cq_entries == $past(pwdata[27:16]))
    else $error("queue sizes not written");

  a_seen_cleared: assert property (
    init_done_reg && wr_status && pwdata[ST_SEEN_BIT] |=> !seen_reg)
    else $error("reset-seen not cleared");

endmodule : csa_regs

//--- tb.sv
// Purpose: Self-checking bench for the controller status and admin
//          queue size register group behind APB.
// Assumes: pready may stall; only the watchdog bounds that wait.
// Notes:   Ordinary register traffic runs from a table, sequencing
//          cases are hand-written after it.

`timescale 1ns/1ns

module tb;
  import csa_pkg::*;

  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  typedef struct {
    logic [11:0] addr;
    logic wr;
    logic [31:0] data;
    logic err;
  } csa_row_type;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic controller_go = 1'b0;
  logic [1:0] shutdown_notify = 2'b00;
  logic subsystem_reset_supported = 1'b1;
  logic pause_request = 1'b0;
  logic fatal_event = 1'b0;
  logic init_fatal_error = 1'b0;
  logic warm_subsystem_reset = 1'b1;
  logic firmware_activated = 1'b0;
  logic controller_ready, controller_reset, subsystem_reset_req;
  logic [11:0] admin_sq_entries, admin_cq_entries;
  logic [15:0] admin_sq_id, admin_cq_id;
  int n_errors = 0;
  int n_compared = 0;
  int n_ssr = 0;
  int n_crst = 0;
  csa_row_type rows [9];

  always #10 pclk = ~pclk;

  csa_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .controller_go(controller_go),
    .shutdown_notify(shutdown_notify),
    .subsystem_reset_supported(subsystem_reset_supported),
    .pause_request(pause_request), .fatal_event(fatal_event),
    .init_fatal_error(init_fatal_error),
    .warm_subsystem_reset(warm_subsystem_reset),
    .firmware_activated(firmware_activated),
    .controller_ready(controller_ready),
    .controller_reset(controller_reset),
    .subsystem_reset_req(subsystem_reset_req),
    .admin_sq_entries(admin_sq_entries),
    .admin_cq_entries(admin_cq_entries),
    .admin_sq_id(admin_sq_id), .admin_cq_id(admin_cq_id)
  );

  // Pulse counters: a pulse seen twice would mean it stood two cycles
  always @(negedge pclk) begin
    if (subsystem_reset_req === 1'b1) n_ssr++;
    if (controller_reset === 1'b1) n_crst++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    check(nm, r & m, x);
  endtask : rd_chk

  // Warm, firmware and fatal straps are sampled on the first edge after release; support acts live
  task automatic do_reset(input logic sup, input logic warm,
                          input logic fw, input logic fat);
    @(posedge pclk);
    presetn <= 1'b0;
    subsystem_reset_supported <= sup;
    warm_subsystem_reset <= warm;
    firmware_activated <= fw;
    init_fatal_error <= fat;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  task automatic wait_neg(input int n);
    repeat (n) @(negedge pclk);
  endtask : wait_neg

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    #(20 * 20000);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int c, n;
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd_chk("status after warm", ADDR_STATUS, 32'hffffffff, 32'h10);
    rd_chk("sizes reset", ADDR_QSIZE, 32'hffffffff, 32'h0);
    wr(ADDR_STATUS, 32'h10);
    rd_chk("seen cleared", ADDR_STATUS, 32'hffffffff, 32'h0);
    check("sq id", admin_sq_id, 32'h0);
    check("cq id", admin_cq_id, 32'h0);

    // Ordinary traffic; reserved bits must read back as zero
    rows = '{'{12'h024, 1'b1, 32'hffffffff, 1'b0},
             '{12'h024, 1'b0, 32'h0fff0fff, 1'b0},
             '{12'h024, 1'b1, 32'h00010001, 1'b0},
             '{12'h024, 1'b0, 32'h00010001, 1'b0},
             '{12'h020, 1'b1, 32'h12345678, 1'b0},
             '{12'h020, 1'b0, 32'h00000000, 1'b0},
             '{12'h030, 1'b1, 32'hffffffff, 1'b1},
             '{12'h030, 1'b0, 32'h00000000, 1'b1},
             '{12'h01c, 1'b0, 32'h00000000, 1'b0}};
    foreach (rows[i]) begin
      apb(rows[i].addr, rows[i].wr, rows[i].data, r, e);
      if (!rows[i].wr) check("table read", r, rows[i].data);
      check("table error", e, rows[i].err);
    end
    check("sq entries", admin_sq_entries, 32'h001);
    check("cq entries", admin_cq_entries, 32'h001);

    // Only the exact key starts a subsystem reset, as one pulse
    c = n_ssr;
    wr(ADDR_SSR_TRIGGER, 32'h4e564d64);
    wait_neg(3);
    check("near key pulses", n_ssr - c, 32'h0);
    wr(ADDR_SSR_TRIGGER, SSR_KEY);
    wait_neg(3);
    check("key pulses", n_ssr - c, 32'h1);
    rd_chk("trigger read", ADDR_SSR_TRIGGER, 32'hffffffff, 32'h0);

    // Ready comes up after go, with pause visible only meanwhile
    @(posedge pclk);
    controller_go <= 1'b1;
    n = 0;
    while (controller_ready !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    // Go is seen one edge late, timer then one state edge, half a cycle
    check("ready delay", n, READY_CYC + 3);
    rd_chk("status ready", ADDR_STATUS, 32'hffffffff, 32'h01);
    @(posedge pclk);
    pause_request <= 1'b1;
    wait_neg(2);
    rd_chk("status paused", ADDR_STATUS, 32'hffffffff, 32'h21);
    c = n_crst;
    @(posedge pclk);
    controller_go <= 1'b0;
    wait_neg(3);
    check("ready after go low", controller_ready, 32'h0);
    check("reset pulses", n_crst - c, 32'h1);
    rd_chk("pause needs go", ADDR_STATUS, 32'h20, 32'h0);
    @(posedge pclk);
    pause_request <= 1'b0;
    repeat (STOP_CYC + 5) @(posedge pclk);
    rd_chk("sizes kept", ADDR_QSIZE, 32'hffffffff, 32'h00010001);

    // Go dropped while still starting: reset pulse, no ready
    c = n_crst;
    @(posedge pclk);
    controller_go <= 1'b1;
    wait_neg(4);
    @(posedge pclk);
    controller_go <= 1'b0;
    wait_neg(3);
    check("abort reset pulses", n_crst - c, 32'h1);
    check("abort ready", controller_ready, 32'h0);
    repeat (STOP_CYC + 5) @(posedge pclk);

    // Every nonzero notify walks busy, then done, then back
    for (int k = 1; k < 4; k++) begin
      @(posedge pclk);
      shutdown_notify <= k[1:0];
      rd_chk("shutdown busy", ADDR_STATUS, 32'h0c, 32'h04);
      repeat (SHDN_CYC + 5) @(posedge pclk);
      rd_chk("shutdown done", ADDR_STATUS, 32'h0c, 32'h08);
      @(posedge pclk);
      shutdown_notify <= 2'b00;
      wait_neg(2);
      rd_chk("shutdown normal", ADDR_STATUS, 32'h0c, 32'h00);
    end

    // Fatal flag is sticky once raised
    @(posedge pclk);
    fatal_event <= 1'b1;
    @(posedge pclk);
    fatal_event <= 1'b0;
    rd_chk("fatal set", ADDR_STATUS, 32'hffffffff, 32'h02);
    repeat (4) @(posedge pclk);
    rd_chk("fatal held", ADDR_STATUS, 32'h02, 32'h02);

    // Init straps: firmware activation, init fatal, no support
    do_reset(1'b1, 1'b1, 1'b1, 1'b1);
    rd_chk("fw activation", ADDR_STATUS, 32'hffffffff, 32'h02);
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk("power-on seen", ADDR_STATUS, 32'hffffffff, 32'h00);
    do_reset(1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk("seen unsupported", ADDR_STATUS, 32'hffffffff, 32'h0);
    c = n_ssr;
    apb(ADDR_SSR_TRIGGER, 1'b1, SSR_KEY, r, e);
    check("reserved write err", e, 32'h0);
    wait_neg(3);
    check("reserved key", n_ssr - c, 32'h0);
    rd_chk("reserved read", ADDR_SSR_TRIGGER, 32'hffffffff, 32'h0);
    tally_and_finish();
  end

endmodule : tb
